// >>> core/odc_clk_div.sv
// Programmable divider producing one enable pulse every ratio_m1+1 cycles
`timescale 1ns/1ps
module odc_clk_div
    import odc_pkg::*;
#(
    parameter int unsigned W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] ratio_m1,
    output logic tick
);
    logic [W-1:0] cnt;

    // Wrap also when the ratio shrinks below the running count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (cnt >= ratio_m1) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else begin
            tick <= (cnt >= ratio_m1);
        end
    end
endmodule

// >>> core/odc_pkg.sv
// Shared constants for the output divider and channel 2 control register bank
package odc_pkg;
    // Register indices; each register sits in one aligned 32-bit word
    localparam logic [7:0] IDX_CH01_DIV = 8'h21;
    localparam logic [7:0] IDX_CH2_CTL = 8'h22;
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CH01_DIV = ADDR_W'(IDX_CH01_DIV * 4);
    localparam logic [ADDR_W-1:0] ADDR_CH2_CTL = ADDR_W'(IDX_CH2_CTL * 4);

    // Reset values
    localparam logic [7:0] CH01_DIV_RST = 8'h01;
    localparam logic SRC_RST = 1'b1;
    localparam logic [1:0] FMT_RST = 2'h1;
    localparam logic [1:0] SETA_RST = 2'h2;
    localparam logic [1:0] SETB_RST = 2'h0;

    // Field positions in the channel 2 control byte
    localparam int unsigned SRC_BIT = 7;
    localparam int unsigned FMT_LO = 5;
    localparam int unsigned SETA_LO = 3;
    localparam int unsigned SETB_LO = 1;
    localparam int unsigned RSVD_BIT = 0;

    // Driver format codes
    localparam logic [1:0] FMT_DISABLED = 2'h0;
    localparam logic [1:0] FMT_AC_DIFF = 2'h1;
    localparam logic [1:0] FMT_HCSL = 2'h2;
    localparam logic [1:0] FMT_LVCMOS = 2'h3;

    // Setting codes shared by the tail, load and single-ended pin fields
    localparam logic [1:0] SET_0 = 2'h0;
    localparam logic [1:0] SET_1 = 2'h1;
    localparam logic [1:0] SET_2 = 2'h2;
    localparam logic [1:0] SET_3 = 2'h3;

    // Tail currents in mA
    localparam logic [4:0] TAIL_MA_0 = 5'h04;
    localparam logic [4:0] TAIL_MA_1 = 5'h06;
    localparam logic [4:0] TAIL_MA_2 = 5'h08;
    localparam logic [4:0] TAIL_MA_3_HCSL = 5'h10;
    localparam logic [4:0] TAIL_MA_3_OTHER = 5'h08;
    localparam logic [4:0] TAIL_MA_OFF = 5'h00;

    // Load resistance in ohms, zero with the high impedance flag
    localparam logic [7:0] LOAD_OHM_1 = 8'h32;
    localparam logic [7:0] LOAD_OHM_2 = 8'h64;
    localparam logic [7:0] LOAD_OHM_3 = 8'hc8;
    localparam logic [7:0] LOAD_OHM_NONE = 8'h00;
endpackage

// >>> core/odc_regs.sv
// APB register bank for the channel 0/1 divider and the channel 2 driver control
`timescale 1ns/1ps
module odc_regs
    import odc_pkg::*;
#(
    parameter int unsigned DIV_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [DIV_W:0] ch01_div_ratio,
    output logic ch01_div_tick,
    output logic ch23_source_select,
    output logic [1:0] ch2_format,
    output logic [4:0] ch2_tail_ma,
    output logic ch2_load_hiz,
    output logic [7:0] ch2_load_ohm,
    output logic ch2_true_drive,
    output logic ch2_true_active,
    output logic ch2_true_invert,
    output logic ch2_comp_drive,
    output logic ch2_comp_active,
    output logic ch2_comp_invert
);
    logic [DIV_W-1:0] ch01_div;
    logic src_sel;
    logic [1:0] fmt;
    logic [1:0] ch2_driver_setting_a;
    logic [1:0] ch2_driver_setting_b;
    logic hit_div;
    logic hit_ctl;
    logic setup_rd;
    logic wr_div;
    logic wr_ctl;
    logic [7:0] ctl_byte;
    logic is_diff;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode: zero wait states, error on unmapped words

    assign hit_div = (paddr == ADDR_CH01_DIV);
    assign hit_ctl = (paddr == ADDR_CH2_CTL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_div || hit_ctl);
    assign setup_rd = psel && !penable && !pwrite;
    assign wr_div = psel && penable && pwrite && hit_div && pstrb[0];
    assign wr_ctl = psel && penable && pwrite && hit_ctl && pstrb[0];
    assign ctl_byte = {src_sel, fmt, ch2_driver_setting_a, ch2_driver_setting_b, 1'b0};

    // Read data is latched in the setup cycle so the access phase sees a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            if (hit_div) begin
                prdata <= 32'(ch01_div);
            end else if (hit_ctl) begin
                prdata <= 32'(ctl_byte);
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch01_div <= CH01_DIV_RST;
        end else if (wr_div) begin
            ch01_div <= pwdata[DIV_W-1:0];
        end
    end

    // Bit 0 of the write data is dropped; the reserved bit has no storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel <= SRC_RST;
            fmt <= FMT_RST;
            ch2_driver_setting_a <= SETA_RST;
            ch2_driver_setting_b <= SETB_RST;
        end else if (wr_ctl) begin
            src_sel <= pwdata[SRC_BIT];
            fmt <= pwdata[FMT_LO +: 2];
            ch2_driver_setting_a <= pwdata[SETA_LO +: 2];
            ch2_driver_setting_b <= pwdata[SETB_LO +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel 0/1 divider

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch01_div_ratio <= (DIV_W+1)'(CH01_DIV_RST) + (DIV_W+1)'(1);
        end else begin
            ch01_div_ratio <= (DIV_W+1)'(ch01_div) + (DIV_W+1)'(1);
        end
    end

    // The divider stands in for the output stage; pclk plays the source clock
    odc_clk_div #(
        .W(DIV_W)
    ) odc_clk_div_i (
        .pclk(pclk),
        .presetn(presetn),
        .ratio_m1(ch01_div),
        .tick(ch01_div_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Channel 2 driver decode

    assign is_diff = (fmt == FMT_AC_DIFF) || (fmt == FMT_HCSL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch23_source_select <= SRC_RST;
            ch2_format <= FMT_RST;
        end else begin
            ch23_source_select <= src_sel;
            ch2_format <= fmt;
        end
    end

    // Tail current only means something in a differential format
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch2_tail_ma <= TAIL_MA_2;
        end else if (!is_diff) begin
            ch2_tail_ma <= TAIL_MA_OFF;
        end else begin
            case (ch2_driver_setting_a)
                SET_0: ch2_tail_ma <= TAIL_MA_0;
                SET_1: ch2_tail_ma <= TAIL_MA_1;
                SET_2: ch2_tail_ma <= TAIL_MA_2;
                default: ch2_tail_ma <= (fmt == FMT_HCSL) ? TAIL_MA_3_HCSL : TAIL_MA_3_OTHER;
            endcase
        end
    end

    // Outside HCSL the load is left open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch2_load_hiz <= 1'b1;
            ch2_load_ohm <= LOAD_OHM_NONE;
        end else if (fmt != FMT_HCSL || ch2_driver_setting_b == SET_0) begin
            ch2_load_hiz <= 1'b1;
            ch2_load_ohm <= LOAD_OHM_NONE;
        end else begin
            ch2_load_hiz <= 1'b0;
            case (ch2_driver_setting_b)
                SET_1: ch2_load_ohm <= LOAD_OHM_1;
                SET_2: ch2_load_ohm <= LOAD_OHM_2;
                default: ch2_load_ohm <= LOAD_OHM_3;
            endcase
        end
    end

    // Single-ended pins: drive when not hi-z, active for codes 2 and 3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch2_true_drive <= 1'b0;
            ch2_true_active <= 1'b0;
            ch2_true_invert <= 1'b0;
        end else begin
            ch2_true_drive <= (fmt == FMT_LVCMOS) && (ch2_driver_setting_a != SET_0);
            ch2_true_active <= (fmt == FMT_LVCMOS) && ch2_driver_setting_a[1];
            ch2_true_invert <= (fmt == FMT_LVCMOS) && (ch2_driver_setting_a == SET_2);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch2_comp_drive <= 1'b0;
            ch2_comp_active <= 1'b0;
            ch2_comp_invert <= 1'b0;
        end else begin
            ch2_comp_drive <= (fmt == FMT_LVCMOS) && (ch2_driver_setting_b != SET_0);
            ch2_comp_active <= (fmt == FMT_LVCMOS) && ch2_driver_setting_b[1];
            ch2_comp_invert <= (fmt == FMT_LVCMOS) && (ch2_driver_setting_b == SET_2);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic div_written;
    logic div_changed;
    logic [DIV_W:0] since_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_written <= 1'b0;
            div_changed <= 1'b1;
            since_tick <= '0;
        end else begin
            div_written <= div_written || wr_div;
            div_changed <= wr_div || (div_changed && !ch01_div_tick);
            since_tick <= ch01_div_tick ? '0 : since_tick + (DIV_W+1)'(1);
        end
    end

    sequence s_wr_div;
        wr_div ##1 1'b1;
    endsequence

    sequence s_wr_ctl;
        wr_ctl ##1 1'b1;
    endsequence

    chk_div_store: assert property (s_wr_div |-> ch01_div == $past(pwdata[DIV_W-1:0]))
        else $error("divider write not stored");
    chk_div_ratio: assert property (wr_div |-> ##2 ch01_div_ratio == (DIV_W+1)'($past(pwdata[DIV_W-1:0], 2)) + 1)
        else $error("divide ratio not value plus one");
    // With the field untouched since the last tick, a tick comes exactly ratio cycles later, never sooner or later
    chk_tick_gap: assert property (!div_changed |->
        ch01_div_tick == (since_tick == ch01_div_ratio - (DIV_W+1)'(1)))
        else $error("divider tick spacing wrong");
    chk_div_reset: assert property (!div_written |-> ch01_div == CH01_DIV_RST && ch01_div_ratio == 9'h002)
        else $error("divider reset value wrong");
    chk_src_follow: assert property (s_wr_ctl |-> ##1 ch23_source_select == $past(pwdata[SRC_BIT], 2))
        else $error("source select not applied");
    chk_fmt_follow: assert property (s_wr_ctl |-> ##1 ch2_format == $past(pwdata[FMT_LO +: 2], 2))
        else $error("driver format not applied");
    chk_tail_hcsl: assert property (fmt == FMT_HCSL && ch2_driver_setting_a == SET_3 |=> ch2_tail_ma == TAIL_MA_3_HCSL)
        else $error("hcsl tail current wrong");
    chk_tail_off: assert property (!is_diff |=> ch2_tail_ma == TAIL_MA_OFF)
        else $error("tail current outside differential");
    chk_true_pin: assert property (fmt == FMT_LVCMOS && ch2_driver_setting_a == SET_1 |=>
        ch2_true_drive && !ch2_true_active)
        else $error("true pin low state wrong");
    chk_load_hcsl: assert property (fmt == FMT_HCSL && ch2_driver_setting_b == SET_3 |=>
        !ch2_load_hiz && ch2_load_ohm == LOAD_OHM_3)
        else $error("hcsl load wrong");
    chk_comp_pin: assert property (fmt == FMT_LVCMOS && ch2_driver_setting_b == SET_2 |=>
        ch2_comp_active && ch2_comp_invert && ch2_comp_drive)
        else $error("complement pin inverted state wrong");
    chk_rsvd_read: assert property (setup_rd && hit_ctl |=> prdata[RSVD_BIT] == 1'b0 && prdata[31:8] == 24'h000000)
        else $error("reserved bit reads nonzero");
endmodule

// >>> dv/odc_regs_tb.sv
// Self-checking testbench for the output divider and channel 2 control register bank
`timescale 1ns/1ps
module odc_regs_tb;
    import odc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [8:0] ch01_div_ratio;
    logic ch01_div_tick;
    logic ch23_source_select;
    logic [1:0] ch2_format;
    logic [4:0] ch2_tail_ma;
    logic ch2_load_hiz;
    logic [7:0] ch2_load_ohm;
    logic ch2_true_drive, ch2_true_active, ch2_true_invert;
    logic ch2_comp_drive, ch2_comp_active, ch2_comp_invert;
    logic [22:0] outs;
    int failures = 0;
    int total_checks = 0;

    assign outs = {ch23_source_select, ch2_format, ch2_tail_ma, ch2_load_hiz, ch2_load_ohm, ch2_true_drive,
                   ch2_true_active, ch2_true_invert, ch2_comp_drive, ch2_comp_active, ch2_comp_invert};

    always #12.5 pclk = ~pclk;

    odc_regs #(.DIV_W(8)) odc_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch01_div_ratio(ch01_div_ratio), .ch01_div_tick(ch01_div_tick),
        .ch23_source_select(ch23_source_select), .ch2_format(ch2_format), .ch2_tail_ma(ch2_tail_ma),
        .ch2_load_hiz(ch2_load_hiz), .ch2_load_ohm(ch2_load_ohm), .ch2_true_drive(ch2_true_drive),
        .ch2_true_active(ch2_true_active), .ch2_true_invert(ch2_true_invert),
        .ch2_comp_drive(ch2_comp_drive), .ch2_comp_active(ch2_comp_active), .ch2_comp_invert(ch2_comp_invert));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Request is held from setup until the edge where pready is seen high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wdata,
                       input logic [3:0] strb, output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wdata;
    endtask

    // Decoded outputs land one cycle after the write edge
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    function automatic logic [2:0] pin(input logic [1:0] f, input logic [1:0] c);
        if (f != 2'h3 || c == 2'h0) return 3'b000;
        return (c == 2'h1) ? 3'b100 : (c == 2'h2) ? 3'b111 : 3'b110;
    endfunction

    function automatic logic [22:0] exp_out(input logic [7:0] v);
        logic [1:0] f;
        logic [1:0] a;
        logic [1:0] b;
        logic [4:0] tail;
        logic [7:0] ohm;
        f = v[6:5];
        a = v[4:3];
        b = v[2:1];
        tail = 5'h00;
        if (f == 2'h1 || f == 2'h2) begin
            tail = (a == 2'h0) ? 5'h04 : (a == 2'h1) ? 5'h06 : (a == 2'h3 && f == 2'h2) ? 5'h10 : 5'h08;
        end
        ohm = (f != 2'h2 || b == 2'h0) ? 8'h00 : (b == 2'h1) ? 8'h32 : (b == 2'h2) ? 8'h64 : 8'hc8;
        return {v[7], f, tail, ohm == 8'h00, ohm, pin(f, a), pin(f, b)};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        logic [31:0] r;
        logic e;
        #1;
        check("ratio after reset", {23'h0, ch01_div_ratio}, 32'h2);
        check("outputs after reset", {9'h0, outs}, {9'h0, exp_out(8'hb0)});
        apb(1'b0, ADDR_CH01_DIV, 32'h0, 4'hf, r, e);
        check("divider reset read", r, 32'h01);
        apb(1'b0, ADDR_CH2_CTL, 32'h0, 4'hf, r, e);
        check("control reset read", r, 32'hb0);
    endtask

    // Boundary ratios and a small one; tick count over three periods proves the real ratio
    task automatic test_divider;
        logic [7:0] vals [3] = '{8'h00, 8'h02, 8'hff};
        logic [31:0] r;
        logic e;
        int ticks;
        foreach (vals[i]) begin
            apb(1'b1, ADDR_CH01_DIV, {24'hffffff, vals[i]}, 4'hf, r, e);
            apb(1'b0, ADDR_CH01_DIV, 32'h0, 4'hf, r, e);
            check("divider read", r, {24'h0, vals[i]});
            settle();
            check("divider ratio", {23'h0, ch01_div_ratio}, {23'h0, vals[i]} + 32'h1);
            ticks = 0;
            repeat (3 * (int'(vals[i]) + 1)) begin
                @(posedge pclk);
                #1;
                if (ch01_div_tick === 1'b1) ticks++;
            end
            check("divider ticks", ticks, 32'h3);
        end
    endtask

    // Every format, every code of both setting fields, both sources
    task automatic test_control;
        logic [7:0] v;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 64; i++) begin
            v = {i[0], i[5:0], 1'b1};
            apb(1'b1, ADDR_CH2_CTL, {24'h0, v}, 4'hf, r, e);
            apb(1'b0, ADDR_CH2_CTL, 32'h0, 4'hf, r, e);
            check("control read", r, {24'h0, v[7:1], 1'b0});
            settle();
            check("control outputs", {9'h0, outs}, {9'h0, exp_out(v)});
        end
    endtask

    // Unmapped place and masked strobe must leave the divider alone
    task automatic test_refused;
        logic [31:0] r;
        logic e;
        apb(1'b1, ADDR_CH01_DIV, 32'h5a, 4'hf, r, e);
        check("mapped write error", {31'h0, e}, 32'h0);
        apb(1'b1, 12'h090, 32'h33, 4'hf, r, e);
        check("unmapped write error", {31'h0, e}, 32'h1);
        apb(1'b0, 12'h090, 32'h0, 4'hf, r, e);
        check("unmapped read error", {31'h0, e}, 32'h1);
        check("unmapped read data", r, 32'h0);
        apb(1'b1, ADDR_CH01_DIV, 32'h77, 4'he, r, e);
        apb(1'b0, ADDR_CH01_DIV, 32'h0, 4'hf, r, e);
        check("divider kept", r, 32'h5a);
        settle();
        check("ratio kept", {23'h0, ch01_div_ratio}, 32'h5b);
    endtask

    // A reset in mid-run must bring back every reset value over written state
    task automatic test_mid_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_divider();
        test_control();
        test_refused();
        test_mid_reset();
        give_verdict();
    end

    // Whole sequence needs under 3000 cycles
    initial begin
        repeat (10000) @(posedge pclk);
        failures++;
        give_verdict();
    end
endmodule
